// >>> hdl/pd_carrier_tx.sv
// carrier pattern transmitter: alternating bits, one bit per bit_time
// assumes start and stop are one-cycle pulses on the core clock
`timescale 1ns/100ps
module pd_carrier_tx #(
  parameter int BIT_CYCLES = pd_self_test_pkg::BIT_TIME_CYCLES,
  parameter int FRAME_BITS = 64
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic powered_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic continuous_i,
  output logic busy_o,
  output logic tx_bit_o
);
  logic [15:0] div;
  logic [15:0] bits;
  logic bit_tick;
  logic stop_pending;

  initial
  begin
    if (BIT_CYCLES < 2 || BIT_CYCLES > 65535 || FRAME_BITS < 1 || FRAME_BITS > 65535)
      $error("pd_carrier_tx: parameter out of range");
  end

  assign bit_tick = busy_o && (div == 16'(BIT_CYCLES - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !busy_o || bit_tick)
      div <= 16'h0000;
    else
      div <= div + 16'h0001;
  end

  // stop request held until the bit boundary that ends the transfer
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !powered_i || !busy_o)
      stop_pending <= 1'b0;
    else if (stop_i)
      stop_pending <= 1'b1;
  end

  // stop wins over start; stop takes effect at the next bit boundary
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !powered_i)
    begin
      busy_o <= 1'b0;
      bits <= 16'h0000;
      tx_bit_o <= 1'b0;
    end
    else if (start_i && !stop_i && !busy_o)
    begin
      busy_o <= 1'b1;
      bits <= 16'h0000;
      tx_bit_o <= 1'b1;
    end
    else if (bit_tick)
    begin
      tx_bit_o <= ~tx_bit_o;
      bits <= bits + 16'h0001;
      if (stop_i || stop_pending || (!continuous_i && bits == 16'(FRAME_BITS - 1)))
        busy_o <= 1'b0;
    end
  end
endmodule // pd_carrier_tx

// >>> hdl/pd_mac_bist_control.sv
// self-test control of the link mac: control registers, rx gating, error tally
// assumes an apb master on clk_sys_i and rx data already in the core clock domain
`timescale 1ns/100ps
module pd_mac_bist_control (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pd_self_test_pkg::rx_beat_t rx_beat_i,
  input wire logic rx_hard_reset_i,
  input wire logic rx_test_error_i,
  output pd_self_test_pkg::rx_beat_t func_beat_o,
  output logic hard_reset_det_o,
  output logic rx_test_active_o,
  output logic rx_pattern_rearm_o,
  output logic tx_phy_power_o,
  output logic tx_bit_o,
  output logic irq_o
);
  // ***********************************************************************
  // apb decode
  // ***********************************************************************
  pd_self_test_pkg::self_test_ctrl_t ctrl;
  logic loopback;
  logic auto_rsp;
  logic [15:0] tally;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic tx_busy;
  logic tx_busy_q;
  logic wr;
  logic rd;
  logic rx_en_rise;
  logic trig;
  logic tx_rst;
  logic blocked;
  logic [2:0] events;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    return a == target;
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit(paddr, pd_self_test_pkg::ADDR_CTRL_A)
    || hit(paddr, pd_self_test_pkg::ADDR_CTRL_B) || hit(paddr, pd_self_test_pkg::ADDR_ERR_HI)
    || hit(paddr, pd_self_test_pkg::ADDR_ERR_LO) || hit(paddr, pd_self_test_pkg::ADDR_RX_CTL)
    || hit(paddr, pd_self_test_pkg::ADDR_IRQ_STAT)
    || hit(paddr, pd_self_test_pkg::ADDR_IRQ_MASK));

  always_comb
  begin
    prdata = 32'h00000000;
    if (hit(paddr, pd_self_test_pkg::ADDR_CTRL_A))
      prdata[4:0] = ctrl;
    else if (hit(paddr, pd_self_test_pkg::ADDR_CTRL_B))
      prdata[0] = tx_busy;
    else if (hit(paddr, pd_self_test_pkg::ADDR_ERR_HI))
      prdata[7:0] = tally[15:8];
    else if (hit(paddr, pd_self_test_pkg::ADDR_ERR_LO))
      prdata[7:0] = tally[7:0];
    else if (hit(paddr, pd_self_test_pkg::ADDR_RX_CTL))
      prdata[1:0] = {auto_rsp, loopback};
    else if (hit(paddr, pd_self_test_pkg::ADDR_IRQ_STAT))
      prdata[2:0] = irq_stat;
    else if (hit(paddr, pd_self_test_pkg::ADDR_IRQ_MASK))
      prdata[2:0] = irq_mask;
  end

  // ***********************************************************************
  // control registers
  // ***********************************************************************
  assign rx_en_rise = wr && hit(paddr, pd_self_test_pkg::ADDR_CTRL_A)
    && pwdata[pd_self_test_pkg::CTRL_A_RX_EN] && !ctrl.rx_self_test_enable;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= '{1'b0, 1'b0, pd_self_test_pkg::PATTERN_RESET};
    end
    else if (wr && hit(paddr, pd_self_test_pkg::ADDR_CTRL_A))
    begin
      ctrl.rx_self_test_enable <= pwdata[pd_self_test_pkg::CTRL_A_RX_EN];
      ctrl.self_test_enable <= pwdata[pd_self_test_pkg::CTRL_A_EN];
      // only the carrier encoding is kept; others fall back to reset value
      if (pwdata[2:0] == pd_self_test_pkg::PATTERN_CARRIER)
        ctrl.tx_test_pattern_select <= pd_self_test_pkg::PATTERN_CARRIER;
      else
        ctrl.tx_test_pattern_select <= pd_self_test_pkg::PATTERN_RESET;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      loopback <= 1'b0;
      auto_rsp <= 1'b0;
      irq_mask <= 3'h0;
    end
    else if (wr && hit(paddr, pd_self_test_pkg::ADDR_RX_CTL))
    begin
      loopback <= pwdata[pd_self_test_pkg::RX_CTL_LOOPBACK];
      auto_rsp <= pwdata[pd_self_test_pkg::RX_CTL_AUTO_RSP];
    end
    else if (wr && hit(paddr, pd_self_test_pkg::ADDR_IRQ_MASK))
      irq_mask <= pwdata[2:0];
  end

  // rearm pulse one cycle after the rising write
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rx_pattern_rearm_o <= 1'b0;
    else
      rx_pattern_rearm_o <= rx_en_rise;
  end
  assign rx_test_active_o = ctrl.rx_self_test_enable;

  // ***********************************************************************
  // error tally
  // ***********************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || rx_en_rise)
      tally <= {pd_self_test_pkg::TALLY_RESET, pd_self_test_pkg::TALLY_RESET};
    else if (wr && hit(paddr, pd_self_test_pkg::ADDR_CTRL_B)
      && pwdata[pd_self_test_pkg::CTRL_B_CLR_ERR])
      tally <= 16'h0000;
    else if (ctrl.rx_self_test_enable && rx_test_error_i && tally != 16'hFFFF)
      tally <= tally + 16'h0001;
  end

  // ***********************************************************************
  // receive gating
  // ***********************************************************************
  assign blocked = ctrl.self_test_enable && loopback;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      func_beat_o <= '0;
      hard_reset_det_o <= 1'b0;
    end
    else
    begin
      func_beat_o <= blocked ? '0 : rx_beat_i;
      hard_reset_det_o <= rx_hard_reset_i && !blocked;
    end
  end

  // ***********************************************************************
  // test transmitter
  // ***********************************************************************
  assign tx_phy_power_o = ctrl.self_test_enable;
  assign tx_rst = wr && hit(paddr, pd_self_test_pkg::ADDR_CTRL_B)
    && pwdata[pd_self_test_pkg::CTRL_B_TX_RESET];
  assign trig = wr && hit(paddr, pd_self_test_pkg::ADDR_CTRL_B)
    && pwdata[pd_self_test_pkg::CTRL_B_TRIGGER] && !tx_rst;

  pd_carrier_tx #(
    .BIT_CYCLES(pd_self_test_pkg::BIT_TIME_CYCLES),
    .FRAME_BITS(64)
  ) u_tx (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .powered_i(ctrl.self_test_enable),
    .start_i(trig),
    .stop_i(tx_rst),
    .continuous_i(ctrl.tx_test_pattern_select == pd_self_test_pkg::PATTERN_CARRIER),
    .busy_o(tx_busy),
    .tx_bit_o(tx_bit_o)
  );

  // ***********************************************************************
  // interrupts: set wins over read clear
  // ***********************************************************************
  assign events = {hard_reset_det_o, rx_test_error_i && ctrl.rx_self_test_enable,
    tx_busy_q && !tx_busy};

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tx_busy_q <= 1'b0;
      irq_stat <= 3'h0;
    end
    else
    begin
      tx_busy_q <= tx_busy;
      if (rd && hit(paddr, pd_self_test_pkg::ADDR_IRQ_STAT))
        irq_stat <= events;
      else
        irq_stat <= irq_stat | events;
    end
  end
  assign irq_o = |(irq_stat & irq_mask);

  // ***********************************************************************
  // checks
  // ***********************************************************************
  a_rearm_on_rise: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_en_rise |=> rx_pattern_rearm_o && rx_test_active_o)
    else $error("rx rearm missing");
  a_tally_cleared: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_en_rise |=> tally == 16'h0000)
    else $error("tally not cleared");
  a_rx_blocked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    blocked |=> !func_beat_o.valid)
    else $error("rx data leaked in loopback");
  a_hard_reset_hidden: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    blocked && $stable(blocked) |=> !hard_reset_det_o)
    else $error("hard reset seen in loopback");
  a_power_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_busy |-> tx_phy_power_o)
    else $error("tx busy without power");
  a_pattern_legal: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ctrl.tx_test_pattern_select == pd_self_test_pkg::PATTERN_RESET
    || ctrl.tx_test_pattern_select == pd_self_test_pkg::PATTERN_CARRIER)
    else $error("illegal pattern stored");
  a_trigger_starts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    trig && ctrl.self_test_enable && !tx_busy |=> tx_busy)
    else $error("trigger did not start tx");
  a_reset_stops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_rst && ctrl.self_test_enable |-> ##[1:335] !tx_busy)
    else $error("tx did not stop in a bit time");
  a_pass_through: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ctrl.self_test_enable && !loopback |=> func_beat_o == $past(rx_beat_i))
    else $error("rx data altered when idle");
endmodule // pd_mac_bist_control

// >>> hdl/pd_self_test_pkg.sv
// constants, types and register map of the link self-test control block
// assumes a 100 MHz core clock and an apb slave port of 32-bit words
package pd_self_test_pkg;

  // ***********************************************************************
  // register map (byte addresses)
  // ***********************************************************************
  localparam logic [15:0] ADDR_CTRL_A = 16'h1AC0;
  localparam logic [15:0] ADDR_CTRL_B = 16'h1AC4;
  localparam logic [15:0] ADDR_ERR_HI = 16'h1AC8;
  localparam logic [15:0] ADDR_ERR_LO = 16'h1ACC;
  localparam logic [15:0] ADDR_RX_CTL = 16'h1AD0;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h1AD4;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h1AD8;

  // ***********************************************************************
  // field positions and values
  // ***********************************************************************
  localparam int CTRL_A_RX_EN = 4;
  localparam int CTRL_A_EN = 3;
  localparam logic [7:0] CTRL_A_WMASK = 8'h1F;
  localparam logic [2:0] PATTERN_RESET = 3'h0;
  localparam logic [2:0] PATTERN_CARRIER = 3'h2;
  localparam int CTRL_B_TRIGGER = 0;
  localparam int CTRL_B_TX_RESET = 1;
  localparam int CTRL_B_CLR_ERR = 2;
  localparam int RX_CTL_LOOPBACK = 0;
  localparam int RX_CTL_AUTO_RSP = 1;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_ERR = 1;
  localparam int IRQ_HARD_RESET = 2;
  localparam logic [7:0] TALLY_RESET = 8'h00;

  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam int CLK_MHZ = 100;
  localparam int BIT_TIME_CYCLES = 334;
  localparam int SETTLE_NS = 5000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic rx_self_test_enable;
    logic self_test_enable;
    logic [2:0] tx_test_pattern_select;
  } self_test_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_beat_t;

endpackage

// >>> verification/pd_line_partner.sv
// line partner model: received beats, hard reset and compare errors
// assumes the core clock; its tasks are called just after a rising edge
`timescale 1ns/100ps
module pd_line_partner (
  input wire logic clk_sys_i,
  output pd_self_test_pkg::rx_beat_t rx_beat_o,
  output logic rx_hard_reset_o,
  output logic rx_test_error_o
);
  initial
  begin
    rx_beat_o = '0;
    rx_hard_reset_o = 1'b0;
    rx_test_error_o = 1'b0;
  end
  // one beat for one cycle, then inverted data while idle
  task automatic send_beat(input logic [7:0] d);
    rx_beat_o <= {1'b1, d};
    @(posedge clk_sys_i);
    rx_beat_o <= {1'b0, ~d};
  endtask
  task automatic send_hard_reset();
    rx_hard_reset_o <= 1'b1;
    @(posedge clk_sys_i);
    rx_hard_reset_o <= 1'b0;
  endtask
  task automatic send_errors(input int n);
    repeat (n)
    begin
      rx_test_error_o <= 1'b1;
      @(posedge clk_sys_i);
      rx_test_error_o <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
endmodule // pd_line_partner

// >>> verification/tb.sv
// self-checking bench of the self-test control block
// assumes the package and design files are compiled first
`timescale 1ns/100ps
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pd_self_test_pkg::rx_beat_t rx_beat;
  pd_self_test_pkg::rx_beat_t func_beat;
  logic rx_hard_reset, rx_test_error, hard_reset_det, rx_test_active;
  logic rx_pattern_rearm, tx_phy_power, tx_bit, irq;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int check_count = 0;
  int rearm_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
    if (rx_pattern_rearm === 1'b1)
      rearm_count++;

  pd_mac_bist_control u_pd_mac_bist_control (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_beat_i(rx_beat),
    .rx_hard_reset_i(rx_hard_reset), .rx_test_error_i(rx_test_error),
    .func_beat_o(func_beat), .hard_reset_det_o(hard_reset_det),
    .rx_test_active_o(rx_test_active), .rx_pattern_rearm_o(rx_pattern_rearm),
    .tx_phy_power_o(tx_phy_power), .tx_bit_o(tx_bit), .irq_o(irq));
  pd_line_partner u_pd_line_partner (
    .clk_sys_i(clk_sys_i), .rx_beat_o(rx_beat),
    .rx_hard_reset_o(rx_hard_reset), .rx_test_error_o(rx_test_error));

  // ************************************
  // shared tasks
  // ************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset_values();
    apb(0, pd_self_test_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'h0);
    apb(0, pd_self_test_pkg::ADDR_ERR_HI, 0);
    chk(rd, 32'h0);
    chk(tx_phy_power, 1'b0);
  endtask
  task automatic t_ctrl_fields();
    int r0;
    r0 = rearm_count;
    apb(1, pd_self_test_pkg::ADDR_CTRL_A, 32'hFF);
    apb(0, pd_self_test_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'h18);
    apb(1, pd_self_test_pkg::ADDR_CTRL_A, 32'h0);
    apb(1, pd_self_test_pkg::ADDR_CTRL_A, 32'h1A);
    apb(0, pd_self_test_pkg::ADDR_CTRL_A, 0);
    chk(rd, 32'h1A);
    chk(rearm_count - r0, 2);
    chk({rx_test_active, tx_phy_power}, 2'b11);
  endtask
  task automatic t_tally();
    u_pd_line_partner.send_errors(3);
    apb(0, pd_self_test_pkg::ADDR_ERR_LO, 0);
    chk(rd, 32'h3);
    apb(0, pd_self_test_pkg::ADDR_IRQ_STAT, 0);
    chk(rd, 32'h2);
    apb(1, pd_self_test_pkg::ADDR_CTRL_A, 32'h0A);
    apb(1, pd_self_test_pkg::ADDR_CTRL_A, 32'h1A);
    apb(0, pd_self_test_pkg::ADDR_ERR_LO, 0);
    chk(rd, 32'h0);
    apb(0, 16'h1AFC, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask
  task automatic t_loopback();
    apb(1, pd_self_test_pkg::ADDR_RX_CTL, 32'h1);
    u_pd_line_partner.send_beat(8'h5A);
    #1 chk(func_beat, 9'h0);
    @(posedge clk_sys_i);
    u_pd_line_partner.send_hard_reset();
    #1 chk(hard_reset_det, 1'b0);
    @(posedge clk_sys_i);
  endtask
  task automatic t_transmit();
    int n;
    repeat (pd_self_test_pkg::SETTLE_CYCLES) @(posedge clk_sys_i);
    apb(1, pd_self_test_pkg::ADDR_CTRL_B, 32'h1);
    apb(0, pd_self_test_pkg::ADDR_CTRL_B, 0);
    chk({rd[0], tx_bit}, 2'b11);
    apb(1, pd_self_test_pkg::ADDR_CTRL_B, 32'h2);
    n = 0;
    do
    begin
      apb(0, pd_self_test_pkg::ADDR_CTRL_B, 0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < pd_self_test_pkg::BIT_TIME_CYCLES / 3 + 4);
    chk(rd, 32'h0);
    apb(1, pd_self_test_pkg::ADDR_CTRL_B, 32'h3);
    apb(0, pd_self_test_pkg::ADDR_CTRL_B, 0);
    chk(rd, 32'h0);
  endtask
  task automatic t_normal_irq();
    apb(1, pd_self_test_pkg::ADDR_CTRL_A, 32'h0);
    apb(1, pd_self_test_pkg::ADDR_RX_CTL, 32'h0);
    apb(1, pd_self_test_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(0, pd_self_test_pkg::ADDR_IRQ_STAT, 0);
    u_pd_line_partner.send_beat(8'hA5);
    #1 chk(func_beat, 9'h1A5);
    @(posedge clk_sys_i);
    u_pd_line_partner.send_hard_reset();
    #1 chk(hard_reset_det, 1'b1);
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk(irq, 1'b0);
    apb(1, pd_self_test_pkg::ADDR_IRQ_MASK, 32'h4);
    chk(irq, 1'b1);
    apb(0, pd_self_test_pkg::ADDR_IRQ_STAT, 0);
    chk(rd, 32'h4);
    chk(irq, 1'b0);
  endtask

  initial
  begin
    #500000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset_values();
    t_ctrl_fields();
    t_tally();
    t_loopback();
    t_transmit();
    t_normal_irq();
    complete_run();
  end
endmodule // tb
